/* File: smc_cfg.svh */
// smc_cfg.svh: constants of the standby mode controller
// assumes inclusion by smc_device, smc_system and the bench of the standby controller
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// power_down_ctrl_reg layout
`define SMC_SBY_BIT         7
`define SMC_HIZ_BIT         6
`define SMC_PDCR_RESET      8'h1f
`define SMC_PDCR_RSVD_MASK  8'h1f
// watchdog wdt_ctrl_status_reg layout
`define SMC_WDT_OVF_BIT     7
`define SMC_WDT_MODE_BIT    6
`define SMC_WDT_RUN_BIT     5
`define SMC_WDT_CTRL_STATUS_REG_RESET      8'h18
`define SMC_WDT_CTRL_STATUS_REG_KEEP_MASK  8'h07
`define SMC_WDT_RESET_CTRL_REG_RESET    8'h1f
// nmi edge polarity encodings
`define SMC_NMI_FALL        1'b0
`define SMC_NMI_RISE        1'b1
// software register offsets of the host end
`define SMC_ADR_CTRL        4'h0
`define SMC_ADR_STAT        4'h1
`define SMC_ADR_PDCR        4'h2
`define SMC_ADR_WDT_CTRL_STATUS_REG        4'h3
`define SMC_ADR_CNT         4'h4
`define SMC_ADR_ICR         4'h5
`endif

/* File: smc_device.sv */
// smc_device.sv: standby entry and exit control of the microcontroller
// assumes mclk models the oscillator; wdt_clk_en gates the watchdog tick
`include "smc_cfg.svh"
`default_nettype none
module smc_device (
    input  wire logic mclk,
    input  wire logic sys_rst,
    smc_if.dev        lnk
);
    typedef struct packed {
        smc_pkg::smc_state_type st;
        logic                   standby_select;
        logic                   port_float_select;
        logic [7:0]             wdt_ctrl_status_reg;
        logic [7:0]             wdt_reset_ctrl_reg;
        logic [7:0]             cnt;
        logic [8:0]             pre;    // wide enough for the slowest rate tap
        logic                   nmi_prev;
        logic                   init_p;
        logic                   exc_p;
    } smc_dev_type;

    smc_dev_type q, d;
    logic        rst_any;
    logic        nmi_hit;
    logic [3:0]  tap;

    assign rst_any = sys_rst | ~lnk.por_pin_n | ~lnk.manual_rst_pin_n;
    assign tap     = smc_pkg::smc_tap(q.wdt_ctrl_status_reg[2:0]);
    // edge decode against nmi_prev, sampled every mclk; standby is left on the next mclk edge
    assign nmi_hit = (lnk.nmi_edge_polarity == `SMC_NMI_FALL) ?
                     (q.nmi_prev & ~lnk.nmi_pin) :
                     (~q.nmi_prev & lnk.nmi_pin);

    // next state
    always_comb begin
        d        = q;
        d.init_p = 1'b0;
        d.exc_p  = 1'b0;
        d.nmi_prev = lnk.nmi_pin;
        if (lnk.pdcr_wr) begin
            // a one is refused while the watchdog runs
            if (!(lnk.pdcr_wdata[`SMC_SBY_BIT] && q.wdt_ctrl_status_reg[`SMC_WDT_RUN_BIT]))
                d.standby_select = lnk.pdcr_wdata[`SMC_SBY_BIT];
            if (!(lnk.pdcr_wdata[`SMC_HIZ_BIT] && q.wdt_ctrl_status_reg[`SMC_WDT_RUN_BIT]))
                d.port_float_select = lnk.pdcr_wdata[`SMC_HIZ_BIT];
        end
        if (lnk.wdt_ctrl_status_reg_wr && q.st == smc_pkg::SMC_RUN)
            d.wdt_ctrl_status_reg = lnk.wdt_ctrl_status_reg_wdata;
        case (q.st)
            smc_pkg::SMC_RUN: begin
                if (lnk.sleep_exec && q.standby_select) begin
                    d.st     = smc_pkg::SMC_STANDBY;
                    d.init_p = 1'b1;
                    // overflow, mode, run cleared; rate kept
                    d.wdt_ctrl_status_reg   = (q.wdt_ctrl_status_reg & `SMC_WDT_CTRL_STATUS_REG_KEEP_MASK) |
                               (`SMC_WDT_CTRL_STATUS_REG_RESET & ~`SMC_WDT_CTRL_STATUS_REG_KEEP_MASK);
                    d.wdt_reset_ctrl_reg = `SMC_WDT_RESET_CTRL_REG_RESET;
                end
            end
            smc_pkg::SMC_STANDBY: begin
                // sby, hiz and counter kept through standby
                if (nmi_hit) begin
                    d.st  = smc_pkg::SMC_WARMUP;
                    d.pre = 9'h000;
                end
            end
            smc_pkg::SMC_WARMUP: begin
                // watchdog counts on its own prescaled tick
                d.pre = q.pre + 9'h001;
                // full tap index, so the slowest rate does not alias to the fastest
                if (q.pre[tap] && !d.pre[tap]) begin
                    d.cnt = q.cnt + 8'h01;
                    if (q.cnt == 8'hff)
                        d.st = smc_pkg::SMC_WAKE;
                end
            end
            smc_pkg::SMC_WAKE: begin
                d.st    = smc_pkg::SMC_RUN;
                d.exc_p = 1'b1;
            end
            default: d.st = smc_pkg::SMC_RUN;
        endcase
    end

    // state register; any reset cancels standby
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            q.st     <= smc_pkg::SMC_RUN;
            q.standby_select    <= 1'b0;
            q.port_float_select    <= 1'b0;
            q.wdt_ctrl_status_reg   <= `SMC_WDT_CTRL_STATUS_REG_RESET;
            q.wdt_reset_ctrl_reg <= `SMC_WDT_RESET_CTRL_REG_RESET;
            q.cnt    <= 8'h00;
            q.pre    <= 9'h000;
            q.nmi_prev <= 1'b0;
            q.init_p <= 1'b0;
            q.exc_p  <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs to the rest of the chip
    assign lnk.pdcr_rdata  = {q.standby_select, q.port_float_select, 1'b0, 5'h1f} & 8'hff;
    assign lnk.wdt_ctrl_status_reg_rdata  = q.wdt_ctrl_status_reg;
    assign lnk.wdt_counter = q.cnt;
    assign lnk.in_standby  = q.st != smc_pkg::SMC_RUN;
    assign lnk.cpu_halt    = lnk.in_standby;
    assign lnk.osc_run     = q.st != smc_pkg::SMC_STANDBY;
    assign lnk.chip_clk_en = q.st == smc_pkg::SMC_RUN;
    assign lnk.wdt_clk_en  = q.st != smc_pkg::SMC_STANDBY;
    assign lnk.port_float  = lnk.in_standby & q.port_float_select;
    assign lnk.port_hold   = lnk.in_standby & ~q.port_float_select;
    assign lnk.periph_init = q.init_p;
    assign lnk.nmi_exc     = q.exc_p;
endmodule : smc_device
`default_nettype wire

/* File: smc_if.sv */
// smc_if.sv: link between the standby controller and its system side
// assumes both ends share mclk and sys_rst
`default_nettype none
interface smc_if;
    logic       sleep_exec;     // pulse: cpu executed sleep
    logic       pdcr_wr;        // pulse: write of power_down_ctrl_reg
    logic [7:0] pdcr_wdata;
    logic [7:0] pdcr_rdata;
    logic       wdt_ctrl_status_reg_wr;        // pulse: write of wdt_ctrl_status_reg
    logic [7:0] wdt_ctrl_status_reg_wdata;
    logic [7:0] wdt_ctrl_status_reg_rdata;
    logic [7:0] wdt_counter;
    logic       nmi_edge_polarity;
    logic       nmi_pin;
    logic       por_pin_n;
    logic       manual_rst_pin_n;
    logic       osc_run;        // level: oscillator enabled
    logic       cpu_halt;       // level: cpu stopped
    logic       chip_clk_en;    // level: clock to whole chip
    logic       wdt_clk_en;     // level: clock to watchdog
    logic       port_hold;      // level: ports keep levels
    logic       port_float;     // level: ports high impedance
    logic       periph_init;    // pulse: peripheral initialise on entry
    logic       nmi_exc;        // pulse: start nmi exception
    logic       in_standby;     // level
    modport dev (
        input  sleep_exec, pdcr_wr, pdcr_wdata, wdt_ctrl_status_reg_wr, wdt_ctrl_status_reg_wdata,
               nmi_edge_polarity, nmi_pin, por_pin_n, manual_rst_pin_n,
        output pdcr_rdata, wdt_ctrl_status_reg_rdata, wdt_counter, osc_run, cpu_halt,
               chip_clk_en, wdt_clk_en, port_hold, port_float,
               periph_init, nmi_exc, in_standby
    );
    modport sys (
        output sleep_exec, pdcr_wr, pdcr_wdata, wdt_ctrl_status_reg_wr, wdt_ctrl_status_reg_wdata,
               nmi_edge_polarity, nmi_pin, por_pin_n, manual_rst_pin_n,
        input  pdcr_rdata, wdt_ctrl_status_reg_rdata, wdt_counter, osc_run, cpu_halt,
               chip_clk_en, wdt_clk_en, port_hold, port_float,
               periph_init, nmi_exc, in_standby
    );
endinterface : smc_if
`default_nettype wire

/* File: smc_pkg.sv */
// smc_pkg.sv: types used by the device end of the standby controller
// assumes smc_cfg.svh is on the include path
`default_nettype none
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_RUN,
        SMC_STANDBY,
        SMC_WARMUP,
        SMC_WAKE
    } smc_state_type;

    // rate select decode to a prescaler tap (used by the device end only)
    function automatic logic [3:0] smc_tap(input logic [2:0] rate);
        smc_tap = {1'b0, rate} + 4'h1;
    endfunction : smc_tap
endpackage : smc_pkg
`default_nettype wire

/* File: smc_props.sv */
// smc_props.sv: assertions on the link joining the two standby controller ends
// assumes one clock mclk and synchronous active-high sys_rst
`default_nettype none
module smc_props (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       sleep_exec,
    input wire logic [7:0] pdcr_rdata,
    input wire logic [7:0] wdt_ctrl_status_reg_rdata,
    input wire logic [7:0] wdt_counter,
    input wire logic       nmi_edge_polarity,
    input wire logic       nmi_pin,
    input wire logic       por_pin_n,
    input wire logic       manual_rst_pin_n,
    input wire logic       osc_run,
    input wire logic       cpu_halt,
    input wire logic       chip_clk_en,
    input wire logic       wdt_clk_en,
    input wire logic       port_hold,
    input wire logic       port_float,
    input wire logic       periph_init,
    input wire logic       nmi_exc,
    input wire logic       in_standby
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic rst_free;
    // both reset pins released
    assign rst_free = por_pin_n && manual_rst_pin_n;
    chk_sleep_enters: assert property (
        sleep_exec && pdcr_rdata[7] && !in_standby && rst_free |=> in_standby)
        else $error("sleep did not enter standby");
    chk_sleep_ignored: assert property (
        sleep_exec && !pdcr_rdata[7] && !in_standby |=> !in_standby)
        else $error("sleep entered standby with select clear");
    chk_standby_stops: assert property (
        in_standby && !wdt_clk_en |-> cpu_halt && !chip_clk_en && !osc_run)
        else $error("clock or cpu running in standby");
    chk_port_mode: assert property (
        in_standby |-> port_float == pdcr_rdata[6] && port_hold == !pdcr_rdata[6])
        else $error("port mode differs from float select");
    chk_entry_init: assert property (
        $rose(in_standby) |-> ##[0:1] periph_init)
        else $error("no peripheral initialise on entry");
    chk_wdt_flags: assert property ($rose(in_standby) |->
        wdt_ctrl_status_reg_rdata[7:5] == 3'h0 && wdt_ctrl_status_reg_rdata[2:0] == $past(wdt_ctrl_status_reg_rdata[2:0]))
        else $error("watchdog status wrong on entry");
    chk_pdcr_kept: assert property ($rose(in_standby) |-> $stable(pdcr_rdata))
        else $error("control register changed on entry");
    chk_nmi_edge: assert property (in_standby && !wdt_clk_en && rst_free &&
        nmi_pin == nmi_edge_polarity && $past(nmi_pin) != nmi_edge_polarity
        |-> ##[1:2] wdt_clk_en) else $error("selected nmi edge did not restart");
    // a pin reset that ends standby also raises wdt_clk_en; only a wake counts here
    chk_wdt_only: assert property ($rose(wdt_clk_en) && $past(rst_free) |->
        !chip_clk_en && osc_run)
        else $error("chip clock not gated in warmup");
    chk_overflow_wake: assert property (
        wdt_clk_en && !chip_clk_en && wdt_counter == 8'hff |-> ##[1:600] nmi_exc)
        else $error("overflow did not wake");
    chk_exc_clock: assert property (nmi_exc |-> chip_clk_en)
        else $error("nmi exception without chip clock");
    chk_por_exit: assert property (!por_pin_n |=> !in_standby && chip_clk_en)
        else $error("power-on reset did not end standby");
    chk_manual_rst_pin_n_exit: assert property (!manual_rst_pin_n |=> !in_standby)
        else $error("manual reset did not end standby");
    // main scenarios
    cover property ($rose(in_standby) && port_float);
    cover property (nmi_exc);
    cover property (in_standby ##1 !por_pin_n);
endmodule : smc_props
`default_nettype wire

/* File: smc_system.sv */
// smc_system.sv: cpu, nmi source and reset side of the standby controller
// assumes software drives the plain register port on mclk
`include "smc_cfg.svh"
`default_nettype none
module smc_system (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    smc_if.sys              lnk,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic       nmi_in,
    input  wire logic       por_n_in,
    input  wire logic       manual_rst_pin_n_n_in
);
    typedef struct packed {
        logic [7:0] rdata;
        logic       sleep;
        logic       pol;
    } smc_sys_type;

    smc_sys_type q, d;

    // register port: ctrl bit0 issues sleep, icr bit0 selects edge
    always_comb begin
        d       = q;
        d.sleep = 1'b0;
        if (wr && addr == `SMC_ADR_CTRL)
            d.sleep = wdata[0];
        if (wr && addr == `SMC_ADR_ICR)
            d.pol = wdata[0];
        d.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `SMC_ADR_STAT: d.rdata = {5'h00, lnk.port_float, lnk.cpu_halt,
                                          lnk.in_standby};
                `SMC_ADR_PDCR: d.rdata = lnk.pdcr_rdata;
                `SMC_ADR_WDT_CTRL_STATUS_REG: d.rdata = lnk.wdt_ctrl_status_reg_rdata;
                `SMC_ADR_CNT:  d.rdata = lnk.wdt_counter;
                `SMC_ADR_ICR:  d.rdata = {7'h00, q.pol};
                default:       d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // orders forwarded to the device end
    assign rdata                 = q.rdata;
    assign lnk.sleep_exec        = q.sleep;
    assign lnk.pdcr_wr           = wr && addr == `SMC_ADR_PDCR;
    assign lnk.pdcr_wdata        = wdata;
    assign lnk.wdt_ctrl_status_reg_wr           = wr && addr == `SMC_ADR_WDT_CTRL_STATUS_REG;
    assign lnk.wdt_ctrl_status_reg_wdata        = wdata;
    assign lnk.nmi_edge_polarity = q.pol;
    assign lnk.nmi_pin           = nmi_in;
    assign lnk.por_pin_n         = por_n_in;
    assign lnk.manual_rst_pin_n  = manual_rst_pin_n_n_in;
endmodule : smc_system
`default_nettype wire

/* File: test_standby_mode_controller.sv */
// test_standby_mode_controller.sv: bench driving the host port of smc_system, which feeds the device end
// assumes smc_cfg.svh on the include path and a 100 MHz mclk
`include "smc_cfg.svh"
`default_nettype none
module test_standby_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk;
    logic       sys_rst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       nmi_in;
    logic       por_n_in;
    logic       manual_rst_pin_n_n_in;
    int         mismatches;
    int         samples_checked;
    int         n;
    smc_if lnk ();
    smc_device i_smc_device (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk));
    smc_system i_smc_system (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .nmi_in(nmi_in),
        .por_n_in(por_n_in), .manual_rst_pin_n_n_in(manual_rst_pin_n_n_in));
    smc_props i_smc_props (.mclk(mclk), .sys_rst(sys_rst), .sleep_exec(lnk.sleep_exec),
        .pdcr_rdata(lnk.pdcr_rdata), .wdt_ctrl_status_reg_rdata(lnk.wdt_ctrl_status_reg_rdata),
        .wdt_counter(lnk.wdt_counter), .nmi_edge_polarity(lnk.nmi_edge_polarity),
        .nmi_pin(lnk.nmi_pin), .por_pin_n(lnk.por_pin_n), .osc_run(lnk.osc_run),
        .manual_rst_pin_n(lnk.manual_rst_pin_n), .cpu_halt(lnk.cpu_halt),
        .chip_clk_en(lnk.chip_clk_en), .wdt_clk_en(lnk.wdt_clk_en),
        .port_hold(lnk.port_hold), .port_float(lnk.port_float),
        .periph_init(lnk.periph_init), .nmi_exc(lnk.nmi_exc), .in_standby(lnk.in_standby));
    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rchk
    // set edge select and control register, sleep, check status
    task automatic enter(input logic [7:0] irq_ctrl_reg, input logic [7:0] pd, input logic [7:0] st);
        wreg(`SMC_ADR_ICR, irq_ctrl_reg);
        wreg(`SMC_ADR_PDCR, pd);
        wreg(`SMC_ADR_CTRL, 8'h01);
        repeat (3) @(posedge mclk);
        rchk(`SMC_ADR_STAT, st);
    endtask : enter
    // drive nmi then count cycles until the exception pulse
    task automatic wake(input logic lvl);
        @(posedge mclk);
        nmi_in <= lvl;
        n = 0;
        while (lnk.nmi_exc !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1 n++;
        end
    endtask : wake
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    // hang guard
    initial begin
        repeat (12000) @(posedge mclk);
        mismatches++;
        conclude();
    end
    // test sequence
    initial begin
        {sys_rst, por_n_in, manual_rst_pin_n_n_in, nmi_in} = 4'hf;
        {addr, wdata, wr, rd} = 14'h0;
        mismatches = 0;
        samples_checked = 0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk(`SMC_ADR_PDCR, 8'h1f);
        rchk(`SMC_ADR_WDT_CTRL_STATUS_REG, 8'h18);
        enter(8'h00, 8'h1f, 8'h00);
        $display("test reset and plain sleep done");
        wreg(`SMC_ADR_WDT_CTRL_STATUS_REG, 8'h19);
        enter(8'h00, 8'h9f, 8'h03);
        rchk(`SMC_ADR_WDT_CTRL_STATUS_REG, 8'h19);
        rchk(`SMC_ADR_PDCR, 8'h9f);
        wake(1'b0);
        chk({7'h0, n >= 2040 && n <= 2080}, 8'h01);
        rchk(`SMC_ADR_STAT, 8'h00);
        $display("test falling wake done");
        enter(8'h01, 8'hdf, 8'h07);
        wake(1'b1);
        rchk(`SMC_ADR_STAT, 8'h00);
        $display("test rising wake done");
        @(posedge mclk);
        nmi_in <= 1'b0;
        enter(8'h01, 8'h9f, 8'h03);
        repeat (20) @(posedge mclk);
        rchk(`SMC_ADR_STAT, 8'h03);
        @(posedge mclk);
        por_n_in <= 1'b0;
        @(posedge mclk);
        por_n_in <= 1'b1;
        rchk(`SMC_ADR_STAT, 8'h00);
        rchk(`SMC_ADR_PDCR, 8'h1f);
        enter(8'h01, 8'h9f, 8'h03);
        @(posedge mclk);
        manual_rst_pin_n_n_in <= 1'b0;
        @(posedge mclk);
        manual_rst_pin_n_n_in <= 1'b1;
        rchk(`SMC_ADR_STAT, 8'h00);
        $display("test reset exits done");
        wreg(`SMC_ADR_WDT_CTRL_STATUS_REG, 8'h38);
        wreg(`SMC_ADR_PDCR, 8'hdf);
        rchk(`SMC_ADR_PDCR, 8'h1f);
        $display("test refused set done");
        conclude();
    end
endmodule : test_standby_mode_controller
`default_nettype wire
